// ### hdl/vpm_pkg.sv
// What this block does
// - Higher priority level always served first
// - Same level: smallest vector number wins
// - Peripheral source levels are software programmable
// - Vector address is base plus entry offset
// - Two words per entry, 19-bit addresses
// - Vectors 0 and 1 never requested
// - Core exceptions 2 to 5 fixed level 3
// - Debug vectors 6,7,9-11 level 1 to 3
// - Low voltage 20, clock synth 21
// - Flash module requests on vectors 22-24
// - CAN controller requests on vectors 26-29
// - SPI channels on vectors 38 to 41
// - Serial interface one on 42,43,45,46
// - Quadrature decoder on vectors 49, 50
// - Program flash 32KB at zero, reserved after
// - Boot flash at boot location, watchdog +2
// - Boot source bit leaves map unchanged
// - Security bit latches flash strap once after reset, writes ignored
// - Data flash read by one bus at a time, core bus first
package vpm_pkg;
  localparam int          NVEC        = 64;            // Vector slots handled
  localparam int          VNUM_W      = 6;             // Vector number width
  localparam int          PADDR_W     = 21;            // Program address width
  localparam int          VADDR_W     = 19;            // Reachable vector address bits
  localparam int          VBASE_SH    = 8;             // Base weight: 0x0200 lands on boot
  // Vectors that have a source in this device
  localparam logic [63:0] VEC_USED    = 64'h0006_6FCE_3DF3_CEFC;
  // Core vectors with a level fixed in hardware
  localparam logic [63:0] VEC_FIXED   = 64'h0000_0000_0001_C03C;
  // Debug unit vectors, level one to three
  localparam logic [63:0] VEC_DEBUG   = 64'h0000_0000_0000_0EC0;
  // Register byte offsets
  localparam logic [7:0]  OFS_OMR     = 8'h00;
  localparam logic [7:0]  OFS_VBASE   = 8'h04;
  localparam logic [7:0]  OFS_EN_LO   = 8'h08;
  localparam logic [7:0]  OFS_EN_HI   = 8'h0C;
  localparam logic [7:0]  OFS_PRIO0   = 8'h10;
  localparam logic [7:0]  OFS_PRIO3   = 8'h1C;
  localparam logic [7:0]  OFS_STATUS  = 8'h20;
  localparam logic [7:0]  OFS_PEND_LO = 8'h24;
  localparam logic [7:0]  OFS_PEND_HI = 8'h28;
  // Field positions
  localparam int          OMR_BOOT_B  = 0;
  localparam int          OMR_SEC_B   = 1;
  localparam int          STAT_VLD_B  = 8;
  // Reset values
  localparam logic [13:0] VBASE_RST   = 14'h0200;
  localparam logic [63:0] EN_RST      = 64'h0000_0000_0000_0000;
  localparam logic [1:0]  PRIO_RST    = 2'h0;
  // Program space map
  localparam logic [20:0] PF_END      = 21'h00_3FFF;
  localparam logic [20:0] BOOT_BASE   = 21'h02_0000;
  localparam logic [20:0] BOOT_END    = 21'h02_0FFF;
  localparam logic [20:0] PRAM_BASE   = 21'h02_F800;
  localparam logic [20:0] PRAM_END    = 21'h02_FFFF;
  localparam logic [20:0] WDOG_OFS    = 21'h00_0002;
  // Program region codes
  localparam logic [1:0]  RGN_PFLASH  = 2'h0;
  localparam logic [1:0]  RGN_BOOT    = 2'h1;
  localparam logic [1:0]  RGN_PRAM    = 2'h2;
  localparam logic [1:0]  RGN_RSVD    = 2'h3;
endpackage : vpm_pkg

// ### hdl/vpm_resolve.sv
`timescale 1ns/1ps
`default_nettype none
module vpm_resolve
  import vpm_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire logic [NVEC-1:0]    elig,
  input  wire logic [2*NVEC-1:0]  lvl,
  output logic                    win_valid,
  output logic [VNUM_W-1:0]       win_num,
  output logic [1:0]              win_level
);
  // Scan upward; strict compare keeps the lowest number at a tie
  always_comb begin
    win_valid = 1'b0;
    win_num   = '0;
    win_level = '0;
    for (int i = 0; i < NVEC; i++) begin
      if (elig[i] && (!win_valid || lvl[2*i +: 2] > win_level)) begin
        win_valid = 1'b1;
        win_num   = VNUM_W'(i);
        win_level = lvl[2*i +: 2];
      end
    end
  end

  // Checker helpers: anything that should have beaten the winner
  logic [NVEC-1:0] higher;
  logic [NVEC-1:0] earlier;
  for (genvar g = 0; g < NVEC; g++) begin : g_chk
    assign higher[g]  = elig[g] && (lvl[2*g +: 2] > win_level);
    assign earlier[g] = elig[g] && (lvl[2*g +: 2] == win_level) && (g < win_num);
  end

  property p_level_order;
    @(posedge ref_clk) disable iff (!resetn) win_valid |-> higher == '0;
  endproperty
  a_level_order: assert property (p_level_order)
    else $error("winner is not at the highest eligible level");

  property p_low_vector;
    @(posedge ref_clk) disable iff (!resetn) win_valid |-> earlier == '0;
  endproperty
  a_low_vector: assert property (p_low_vector)
    else $error("lower vector at same level was skipped");
endmodule : vpm_resolve
`default_nettype wire

// ### hdl/vpm_top.sv
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module vpm_top
  import vpm_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // Interrupt sources and core
  input  wire logic [NVEC-1:0]    irq_req,
  input  wire logic [1:0]         core_mask_level,
  output logic                    vec_req,
  output logic [VNUM_W-1:0]       vec_num,
  output logic [1:0]              vec_level,
  output logic [PADDR_W-1:0]      vec_addr,
  // Program space decode
  input  wire logic [PADDR_W-1:0] prog_addr,
  output logic [1:0]              prog_region,
  output logic [PADDR_W-1:0]      reset_fetch_addr,
  output logic [PADDR_W-1:0]      wdog_fetch_addr,
  // Mode bits
  input  wire logic               flash_secure_in,
  output logic                    boot_source_select_bit,
  output logic                    flash_security_state_bit,
  // Data flash read ports
  input  wire logic               dflash_rd_core,
  input  wire logic               dflash_rd_sec,
  output logic                    dflash_grant_core,
  output logic                    dflash_grant_sec
);
  // Bus data phase state
  logic                 wr_q;          // Write data phase pending
  logic                 rd_q;          // Read wait state pending
  logic                 map_q;         // Address inside the block
  logic [7:0]           ofs_q;         // Latched byte offset
  logic                 hreadyout_q;
  logic                 hresp_q;
  logic [31:0]          hrdata_q;
  logic [31:0]          rdata_d;
  // Software state
  logic [13:0]          vbase_q;       // Vector table base
  logic [NVEC-1:0]      en_q;          // Per-source enable
  logic [1:0]           prio_q [NVEC]; // Programmed levels
  logic                 boot_sel_q;    // Boot source mode bit
  // Security strap path
  logic                 sec_s1_q;
  logic                 sec_s2_q;
  logic                 sec_q;
  logic                 sec_done_q;    // Strap already captured
  // Resolution
  logic [2*NVEC-1:0]    lvl;
  logic [NVEC-1:0]      elig;
  logic                 win_valid;
  logic [VNUM_W-1:0]    win_num;
  logic [1:0]           win_level;
  logic                 vec_req_q;
  logic [VNUM_W-1:0]    vec_num_q;
  logic [1:0]           vec_level_q;
  logic [PADDR_W-1:0]   vec_addr_q;
  logic [PADDR_W-1:0]   vec_addr_d;
  // Program map and data flash
  logic [1:0]           region_q;
  logic [PADDR_W-1:0]   rst_addr_q;
  logic [PADDR_W-1:0]   wdog_addr_q;
  logic                 gnt_core_q;
  logic                 gnt_sec_q;

  logic                 take;          // Address phase accepted
  logic                 wr_hit;        // Write data phase in range
  assign take   = hsel && htrans[1] && hready;
  assign wr_hit = wr_q && map_q;

  // Address phase capture; reads get one wait state so that a read
  // right behind a write sees the freshly written value
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_q        <= 1'b0;
      rd_q        <= 1'b0;
      map_q       <= 1'b0;
      ofs_q       <= '0;
      hreadyout_q <= 1'b1;
    end else begin
      if (take) begin
        wr_q  <= hwrite;
        rd_q  <= !hwrite;
        map_q <= (haddr[31:8] == 24'h00_0000);
        ofs_q <= {haddr[7:2], 2'b00};
      end else if (hreadyout_q) begin
        wr_q <= 1'b0;
        rd_q <= 1'b0;
      end
      if (take && !hwrite) begin
        hreadyout_q <= 1'b0;
      end else begin
        hreadyout_q <= 1'b1;
      end
      if (!hreadyout_q) begin
        rd_q <= 1'b0;
      end
    end
  end

  // Only OKAY is ever answered, unmapped reads return zero
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
    end
  end

  // Read multiplexer
  always_comb begin
    rdata_d = '0;
    if (map_q) begin
      case (ofs_q)
        OFS_OMR: begin
          rdata_d[OMR_BOOT_B] = boot_sel_q;
          rdata_d[OMR_SEC_B]  = sec_q;
        end
        OFS_VBASE:   rdata_d[13:0] = vbase_q;
        OFS_EN_LO:   rdata_d = en_q[31:0];
        OFS_EN_HI:   rdata_d = en_q[63:32];
        OFS_STATUS:  rdata_d = {23'h00_0000, vec_req_q, vec_level_q, vec_num_q};
        OFS_PEND_LO: rdata_d = elig[31:0];
        OFS_PEND_HI: rdata_d = elig[63:32];
        default: begin
          if (ofs_q >= OFS_PRIO0 && ofs_q <= OFS_PRIO3) begin
            for (int k = 0; k < 16; k++) begin
              rdata_d[2*k +: 2] = prio_q[{ofs_q[3:2], 4'(k)}];
            end
          end
        end
      endcase
    end
  end

  // Read data is registered in the wait state
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      hrdata_q <= '0;
    end else if (rd_q && !hreadyout_q) begin
      hrdata_q <= rdata_d;
    end
  end

  // Base, enables and mode bit; the security bit ignores writes
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      vbase_q    <= VBASE_RST;
      en_q       <= EN_RST;
      boot_sel_q <= 1'b0;
    end else if (wr_hit) begin
      case (ofs_q)
        OFS_OMR:   boot_sel_q   <= hwdata[OMR_BOOT_B];
        OFS_VBASE: vbase_q      <= hwdata[13:0];
        OFS_EN_LO: en_q[31:0]   <= hwdata;
        OFS_EN_HI: en_q[63:32]  <= hwdata;
        default: ;
      endcase
    end
  end

  // Level table; a word holds sixteen two-bit levels
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int v = 0; v < NVEC; v++) begin
        prio_q[v] <= PRIO_RST;
      end
    end else if (wr_hit && ofs_q >= OFS_PRIO0 && ofs_q <= OFS_PRIO3) begin
      for (int k = 0; k < 16; k++) begin
        prio_q[{ofs_q[3:2], 4'(k)}] <= hwdata[2*k +: 2];
      end
    end
  end

  // Effective level and eligibility per vector
  for (genvar g = 0; g < NVEC; g++) begin : g_vec
    localparam logic [1:0] FIX = (g < 6) ? 2'h3 : (g == 14) ? 2'h2 : (g == 15) ? 2'h1 : 2'h0;
    if (VEC_FIXED[g]) begin : g_fix
      assign lvl[2*g +: 2] = FIX;
    end else if (VEC_DEBUG[g]) begin : g_dbg
      // Zero is not a legal debug level, so it reads as one
      assign lvl[2*g +: 2] = (prio_q[g] == 2'h0) ? 2'h1 : prio_q[g];
    end else begin : g_per
      // Level three is kept for the core, clamp to two
      assign lvl[2*g +: 2] = (prio_q[g] == 2'h3) ? 2'h2 : prio_q[g];
    end
    // Unused and reserved slots, 0 and 1 among them, never fire
    assign elig[g] = irq_req[g] && VEC_USED[g] && (VEC_FIXED[g] || en_q[g])
                     && (lvl[2*g +: 2] >= core_mask_level);
  end

  vpm_resolve u_resolve (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .elig      (elig),
    .lvl       (lvl),
    .win_valid (win_valid),
    .win_num   (win_num),
    .win_level (win_level)
  );

  // Entry is two words wide, upper address bits cut off
  assign vec_addr_d = ((PADDR_W'(vbase_q) << VBASE_SH) + PADDR_W'({win_num, 1'b0}))
                      & PADDR_W'({VADDR_W{1'b1}});

  // Vector request towards the core
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      vec_req_q   <= 1'b0;
      vec_num_q   <= '0;
      vec_level_q <= '0;
      vec_addr_q  <= '0;
    end else begin
      vec_req_q   <= win_valid;
      vec_num_q   <= win_num;
      vec_level_q <= win_level;
      vec_addr_q  <= vec_addr_d;
    end
  end

  // Pin synchroniser runs through reset, so the strap is settled at release
  always_ff @(posedge ref_clk) begin
    sec_s1_q <= flash_secure_in;
    sec_s2_q <= sec_s1_q;
  end

  // Strap caught debug_unit after reset release
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sec_q      <= 1'b0;
      sec_done_q <= 1'b0;
    end else begin
      if (!sec_done_q) begin
        sec_q      <= sec_s2_q;
        sec_done_q <= 1'b1;
      end
    end
  end

  // Program region decode; boot source bit takes no part
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      region_q    <= RGN_RSVD;
      rst_addr_q  <= '0;
      wdog_addr_q <= '0;
    end else begin
      rst_addr_q  <= BOOT_BASE;
      wdog_addr_q <= BOOT_BASE + WDOG_OFS;
      if (prog_addr <= PF_END) begin
        region_q <= RGN_PFLASH;
      end else if (prog_addr >= BOOT_BASE && prog_addr <= BOOT_END) begin
        region_q <= RGN_BOOT;
      end else if (prog_addr >= PRAM_BASE && prog_addr <= PRAM_END) begin
        region_q <= RGN_PRAM;
      end else begin
        region_q <= RGN_RSVD;
      end
    end
  end

  // Data flash has one read port; core bus wins a clash
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      gnt_core_q <= 1'b0;
      gnt_sec_q  <= 1'b0;
    end else begin
      gnt_core_q <= dflash_rd_core;
      gnt_sec_q  <= dflash_rd_sec && !dflash_rd_core;
    end
  end

  assign hreadyout                = hreadyout_q;
  assign hresp                    = hresp_q;
  assign hrdata                   = hrdata_q;
  assign vec_req                  = vec_req_q;
  assign vec_num                  = vec_num_q;
  assign vec_level                = vec_level_q;
  assign vec_addr                 = vec_addr_q;
  assign prog_region              = region_q;
  assign reset_fetch_addr         = rst_addr_q;
  assign wdog_fetch_addr          = wdog_addr_q;
  assign boot_source_select_bit   = boot_sel_q;
  assign flash_security_state_bit = sec_q;
  assign dflash_grant_core        = gnt_core_q;
  assign dflash_grant_sec         = gnt_sec_q;

  // Checks
  property p_no_req;
    @(posedge ref_clk) disable iff (!resetn) (elig == '0) |=> !vec_req_q;
  endproperty
  a_no_req: assert property (p_no_req)
    else $error("vector request without eligible source");

  property p_addr;
    @(posedge ref_clk) disable iff (!resetn)
      vec_req_q |-> vec_addr_q[0] == 1'b0 && vec_addr_q[20:19] == 2'h0;
  endproperty
  a_addr: assert property (p_addr)
    else $error("vector address not word pair or too wide");

  property p_addr_calc;
    @(posedge ref_clk) disable iff (!resetn)
      win_valid && $stable(vbase_q) |=>
        vec_addr_q[18:0] == 19'(($past(vbase_q) << VBASE_SH) + 2 * vec_num_q);
  endproperty
  a_addr_calc: assert property (p_addr_calc)
    else $error("vector address not base plus twice number");

  property p_reserved;
    @(posedge ref_clk) disable iff (!resetn) vec_req_q |-> vec_num_q > 6'h01;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved reset vector requested");

  property p_fixed;
    @(posedge ref_clk) disable iff (!resetn)
      vec_req_q && vec_num_q >= 6'h02 && vec_num_q <= 6'h05 |-> vec_level_q == 2'h3;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("core exception not at level three");

  property p_periph;
    @(posedge ref_clk) disable iff (!resetn)
      vec_req_q && vec_num_q >= 6'h14 |-> vec_level_q != 2'h3;
  endproperty
  a_periph: assert property (p_periph)
    else $error("peripheral request at level three");

  property p_debug;
    @(posedge ref_clk) disable iff (!resetn)
      vec_req_q && VEC_DEBUG[vec_num_q] |-> vec_level_q != 2'h0;
  endproperty
  a_debug: assert property (p_debug)
    else $error("debug request at level zero");

  property p_pflash;
    @(posedge ref_clk) disable iff (!resetn)
      prog_addr > PF_END && prog_addr < BOOT_BASE |=> region_q == RGN_RSVD;
  endproperty
  a_pflash: assert property (p_pflash)
    else $error("gap above program flash not reserved");

  property p_wdog;
    @(posedge ref_clk) disable iff (!resetn)
      $past(resetn) |-> wdog_addr_q == rst_addr_q + 21'h00_0002;
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog address not two above boot");

  property p_sec_hold;
    @(posedge ref_clk) disable iff (!resetn) sec_done_q |=> $stable(sec_q);
  endproperty
  a_sec_hold: assert property (p_sec_hold)
    else $error("security bit changed after reset");

  property p_dflash;
    @(posedge ref_clk) disable iff (!resetn) !(gnt_core_q && gnt_sec_q);
  endproperty
  a_dflash: assert property (p_dflash)
    else $error("data flash granted to both buses");
endmodule : vpm_top
`default_nettype wire

// ### dv/vpm_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core plus request sources: lines hold until the core takes one
module vpm_core_model (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        load,
  input  wire logic [63:0] load_val,
  input  wire logic        svc_on,
  input  wire logic [2:0]  ack_gap,
  input  wire logic        vec_req,
  input  wire logic [5:0]  vec_num,
  output logic      [63:0] irq_req,
  output logic             ack,
  output logic      [5:0]  ack_num
);
  logic [2:0] gap_q;  // Cycles left before the next service
  // Gap of one or more lets the stale winner drain before next take
  always_ff @(posedge ref_clk) begin
    ack <= 1'b0;
    if (!resetn) begin
      irq_req <= 64'h0;
      gap_q   <= 3'h0;
      ack_num <= 6'h0;
    end else if (load) begin
      irq_req <= load_val;
    end else if (gap_q != 3'h0) begin
      gap_q <= gap_q - 3'h1;
    end else if (svc_on && vec_req && irq_req[vec_num]) begin
      // Source clears its own line debug_unit serviced
      irq_req[vec_num] <= 1'b0;
      ack              <= 1'b1;
      ack_num          <= vec_num;
      gap_q            <= ack_gap;
    end
  end
endmodule : vpm_core_model
`default_nettype wire

// ### dv/tb_vector_priority_and_program_map.sv
`timescale 1ns/1ps
`default_nettype none
module tb_vector_priority_and_program_map;
  import vpm_pkg::*;
  logic                ref_clk;
  logic                resetn = 1'b0;
  logic                hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0]         haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0]          htrans = 2'h0, mask = 2'h0;
  logic [2:0]          hsize = 3'h2, gap = 3'h1;
  logic                vec_req, boot_bit, sec_bit, g_core, g_sec, ack;
  logic [VNUM_W-1:0]   vec_num, ack_num;
  logic [1:0]          vec_level, region;
  logic [PADDR_W-1:0]  vec_addr, rfa, wfa, paddr = 21'h0;
  logic                sec_in = 1'b1, rd_c = 1'b0, rd_s = 1'b0, load = 1'b0, svc = 1'b0;
  logic [63:0]         irq, lval = 64'h0, v, pend, en_m = 64'h0;
  logic [1:0]          lv_m [64];
  logic [13:0]         vb_m = 14'h0200;
  logic [20:0]         tbl [12] = '{21'h0, 21'h3FFF, 21'h4000, 21'h1FFFF, 21'h20000,
    21'h20FFF, 21'h21000, 21'h2F7FF, 21'h2F800, 21'h2FFFF, 21'h30000, 21'h1FFFFF};
  int                  error_cnt = 0, samples_checked = 0, cyc = 0, w, e;

  // Free running clock, 5 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  vpm_top uut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_req(irq),
    .core_mask_level(mask), .vec_req(vec_req), .vec_num(vec_num), .vec_level(vec_level),
    .vec_addr(vec_addr), .prog_addr(paddr), .prog_region(region), .reset_fetch_addr(rfa),
    .wdog_fetch_addr(wfa), .flash_secure_in(sec_in), .boot_source_select_bit(boot_bit),
    .flash_security_state_bit(sec_bit), .dflash_rd_core(rd_c), .dflash_rd_sec(rd_s),
    .dflash_grant_core(g_core), .dflash_grant_sec(g_sec));

  vpm_core_model src_core (.ref_clk(ref_clk), .resetn(resetn), .load(load),
    .load_val(lval), .svc_on(svc), .ack_gap(gap), .vec_req(vec_req), .vec_num(vec_num),
    .irq_req(irq), .ack(ack), .ack_num(ack_num));

  // Verdict and end of run, reached from the sequence or the hang guard
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // Single value compare, four-state exact
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  // One AHB-Lite single word transfer; waits on hready, no fixed latency
  task automatic ahb(input logic wr_i, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd_o);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr_i;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd_o = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask : ahb

  task automatic rd(logic [31:0] a, logic [31:0] exp, string what);
    logic [31:0] t;
    ahb(1'b0, a, 32'h0, t);
    chk(what, exp, t);
  endtask : rd

  // Effective level of a source, -1 for a slot with no source
  function automatic int eff(int n);
    int raw;
    raw = lv_m[n];
    if (n >= 2 && n <= 5) return 3;
    if (n == 14) return 2;
    if (n == 15) return 1;
    if (n == 16) return 0;
    if (n inside {6, 7, 9, 10, 11}) return (raw == 0) ? 1 : raw;
    if (n inside {17, 20, 21, 22, 23, 24, 26, 27, 28, 29, 33, 34, 35, 38, 39, 40, 41, 42,
                  43, 45, 46, 49, 50}) return (raw == 3) ? 2 : raw;
    return -1;
  endfunction : eff

  // Winner: highest level first, lowest number within a level
  function automatic int win(logic [63:0] p, logic [1:0] m);
    int b, bl;
    b  = -1;
    bl = -1;
    for (int n = 0; n < 64; n++)
      if (p[n] && eff(n) >= m && eff(n) > bl &&
          (en_m[n] || (n >= 2 && n <= 5) || (n >= 14 && n <= 16))) begin
        b  = n;
        bl = eff(n);
      end
    return b;
  endfunction : win

  // Present a request set and mask, then compare the vector outputs
  task automatic src(logic [63:0] val, logic [1:0] m);
    @(posedge ref_clk);
    load <= 1'b1;
    lval <= val;
    @(posedge ref_clk);
    // Mask moves with the new request set, so no stale mix is served
    load <= 1'b0;
    mask <= m;
    repeat (2) @(posedge ref_clk);
    #1;
    w = win(val, m);
    chk("vec_req", 32'(w >= 0), 32'(vec_req));
    if (w >= 0) begin
      chk("vec_num", w, 32'(vec_num));
      chk("vec_level", eff(w), 32'(vec_level));
      chk("vec_addr", ((32'(vb_m) << VBASE_SH) + 32'(2 * w)) & 32'h7FFFF, 32'(vec_addr));
    end
  endtask : src

  task automatic setlv(int wd, logic [31:0] val);
    ahb(1'b1, 32'(OFS_PRIO0) + 32'(4 * wd), val, r);
    for (int k = 0; k < 16; k++) lv_m[16 * wd + k] = val[2 * k +: 2];
    rd(32'(OFS_PRIO0) + 32'(4 * wd), val, "lvl_word");
  endtask : setlv

  function automatic logic [1:0] rgn(logic [20:0] a);
    if (a <= 21'h3FFF) return 2'h0;
    if (a >= 21'h20000 && a <= 21'h20FFF) return 2'h1;
    if (a >= 21'h2F800 && a <= 21'h2FFFF) return 2'h2;
    return 2'h3;
  endfunction : rgn

  // Decode table plus random addresses, one cycle latency
  task automatic dec_run();
    logic [20:0] a;
    for (int i = 0; i < 32; i++) begin
      a = (i < 12) ? tbl[i] : 21'($urandom);
      @(posedge ref_clk);
      paddr <= a;
      @(posedge ref_clk);
      #1;
      chk("region", 32'(rgn(a)), 32'(region));
    end
  endtask : dec_run

  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      $display("BAD timeout exp done got hang");
      tally_and_finish();
    end
  end

  initial begin
    for (int n = 0; n < 64; n++) lv_m[n] = 2'h0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    void'($urandom(55));
    repeat (3) @(posedge ref_clk);
    // Reset values, unmapped places, fetch addresses
    rd(32'(OFS_OMR), 32'h2, "omr_rst");
    rd(32'(OFS_VBASE), 32'h0200, "vbase_rst");
    rd(32'(OFS_EN_LO), 32'h0, "en_lo_rst");
    rd(32'(OFS_EN_HI), 32'h0, "en_hi_rst");
    for (int i = 0; i < 4; i++) rd(32'(OFS_PRIO0) + 32'(4 * i), 32'h0, "lvl_rst");
    rd(32'h2C, 32'h0, "unmapped");
    rd(32'h100, 32'h0, "out_of_page");
    chk("reset_fetch", 32'h20000, 32'(rfa));
    chk("wdog_fetch", 32'h20002, 32'(wfa));
    // Reset base puts entries 0 and 1 on the two reset fetch addresses
    chk("entry0", 32'(VBASE_RST) << VBASE_SH, 32'(rfa));
    chk("entry1", (32'(VBASE_RST) << VBASE_SH) + 32'h2, 32'(wfa));
    // Every slot alone: reserved ones never raise a request
    vb_m = 14'($urandom);
    ahb(1'b1, 32'(OFS_VBASE), 32'(vb_m), r);
    rd(32'(OFS_VBASE), 32'(vb_m), "vbase");
    en_m = {64{1'b1}};
    ahb(1'b1, 32'(OFS_EN_LO), 32'hFFFFFFFF, r);
    ahb(1'b1, 32'(OFS_EN_HI), 32'hFFFFFFFF, r);
    for (int i = 0; i < 4; i++) setlv(i, 32'hAAAAAAAA);
    for (int n = 0; n < 64; n++) src(64'h1 << n, 2'h0);
    // Random sets, masks, levels and enables
    for (int i = 0; i < 150; i++) begin
      if (i % 16 == 0) begin
        setlv(i / 16 % 4, $urandom);
        en_m = {$urandom, $urandom} | {$urandom, $urandom};
        ahb(1'b1, 32'(OFS_EN_LO), en_m[31:0], r);
        ahb(1'b1, 32'(OFS_EN_HI), en_m[63:32], r);
      end
      v = {$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom};
      src(v, 2'($urandom));
      if (w >= 0) rd(32'(OFS_STATUS), {23'h0, 1'b1, 2'(eff(w)), 6'(w)}, "status");
    end
    // Service order as the core takes requests, prompt and slow
    src(64'h0, 2'h0);
    svc <= 1'b1;
    for (int j = 0; j < 8; j++) begin
      pend = {$urandom, $urandom} & {$urandom, $urandom};
      gap  <= 3'(1 + j % 7);
      src(pend, 2'(j % 3));
      for (int i = 0; i < 64; i++) begin
        e = win(pend, mask);
        if (e >= 0) begin
          do @(posedge ref_clk); while (ack !== 1'b1);
          chk("ack_num", e, 32'(ack_num));
          pend[e] = 1'b0;
        end
      end
      repeat (10) @(posedge ref_clk);
      #1;
      chk("idle_req", 32'h0, 32'(vec_req));
      chk("left_lo", pend[31:0], irq[31:0]);
      chk("left_hi", pend[63:32], irq[63:32]);
    end
    svc <= 1'b0;
    // Program map, then boot bit set and security write tried
    dec_run();
    ahb(1'b1, 32'(OFS_OMR), 32'h1, r);
    sec_in <= 1'b0;
    rd(32'(OFS_OMR), 32'h3, "omr");
    chk("boot_bit", 32'h1, 32'(boot_bit));
    chk("sec_bit", 32'h1, 32'(sec_bit));
    dec_run();
    // Data flash read ports: never both granted
    for (int i = 0; i < 20; i++) begin
      v = (i < 4) ? 64'(i) : 64'($urandom);
      @(posedge ref_clk);
      rd_c <= v[0];
      rd_s <= v[1];
      @(posedge ref_clk);
      #1;
      chk("grant_core", 32'(v[0]), 32'(g_core));
      chk("grant_sec", 32'(v[1] & ~v[0]), 32'(g_sec));
    end
    tally_and_finish();
  end
endmodule : tb_vector_priority_and_program_map
`default_nettype wire
